// [design/gate_cfg_pkg.sv]
package gate_cfg_pkg;
  // ***************************************************************
  // link message codes
  // ***************************************************************
  localparam logic [7:0] CODE_MASK    = 8'h3F; // message number bits
  localparam logic [7:0] REQ_FLAG     = 8'h80; // host request marker
  localparam logic [7:0] ACK_FLAG     = 8'h40; // acknowledged answer
  localparam logic [7:0] MSG_SET_PROT = 8'h01;
  localparam logic [7:0] MSG_GET_PROT = 8'h02;
  localparam logic [7:0] MSG_SET_DAC  = 8'h03;
  localparam logic [7:0] MSG_GET_DAC  = 8'h04;
  localparam logic [7:0] MSG_SET_TIME = 8'h07;
  localparam logic [7:0] MSG_GET_TIME = 8'h08;

  // ***************************************************************
  // register layouts and reset values
  // ***************************************************************
  localparam logic [7:0] PROT_RESET   = 8'h00;
  localparam logic [7:0] PROT_UNUSED  = 8'hB0; // bits 7,5,4 must be 0
  localparam logic [7:0] DAC_RESET    = 8'h00;
  localparam logic [7:0] TIME_RESET   = 8'h00;
  localparam logic [7:0] TIME_UNUSED  = 8'hF0; // bits 7:4 must be 0

  typedef struct packed {
    logic       unused7;
    logic       pullupDisconnect; // bit 6
    logic [1:0] reserved54;
    logic       uvloDisable;      // bit 3
    logic       ocDetectDisable;  // bit 2
    logic [1:0] ocThreshold;      // bits 1:0
  } protection_t;

  typedef struct packed {
    logic [3:0] unused74;
    logic [1:0] deadSel;          // bits 3:2
    logic [1:0] blankSel;         // bits 1:0
  } timing_t;

  // ***************************************************************
  // timing figures in ns, counts derived at 25 MHz
  // ***************************************************************
  localparam int CLK_MHZ   = 25;
  localparam int DEAD0_NS  = 2000;
  localparam int DEAD1_NS  = 1000;
  localparam int DEAD2_NS  = 500;
  localparam int DEAD3_NS  = 250;
  localparam int BLANK0_NS = 4000;
  localparam int BLANK1_NS = 2000;
  localparam int BLANK2_NS = 1000;
  localparam int BLANK3_NS = 500;
  localparam int CW        = 8;   // counter width

  // least times round up to whole cycles
  function automatic logic [CW-1:0] nsToCycles(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    if (c < 1) c = 1;
    return c[CW-1:0];
  endfunction

  localparam logic [CW-1:0] DEAD0_CYC  = nsToCycles(DEAD0_NS);
  localparam logic [CW-1:0] DEAD1_CYC  = nsToCycles(DEAD1_NS);
  localparam logic [CW-1:0] DEAD2_CYC  = nsToCycles(DEAD2_NS);
  localparam logic [CW-1:0] DEAD3_CYC  = nsToCycles(DEAD3_NS);
  localparam logic [CW-1:0] BLANK0_CYC = nsToCycles(BLANK0_NS);
  localparam logic [CW-1:0] BLANK1_CYC = nsToCycles(BLANK1_NS);
  localparam logic [CW-1:0] BLANK2_CYC = nsToCycles(BLANK2_NS);
  localparam logic [CW-1:0] BLANK3_CYC = nsToCycles(BLANK3_NS);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DATA  = 2'b01,
    ST_FIRST = 2'b10,
    ST_SECOND= 2'b11
  } msg_state_t;
endpackage

// [design/phase_dead_time.sv]
`timescale 1ns/1ps
`default_nettype none
module phase_dead_time import gate_cfg_pkg::*; (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstN,
  // pwm requests and selected gap
  input  wire logic          highPwm,
  input  wire logic          lowPwm,
  input  wire logic [CW-1:0] deadCycles,
  // gate drive and switch event
  output logic               highGate,
  output logic               lowGate,
  output logic               switched
);
  // ***************************************************************
  // gap between sides
  // ***************************************************************
  logic [1:0]    gate_r;   // {high, low}
  logic [CW-1:0] cnt_r;    // remaining off cycles
  // both requested means shoot-through: keep both off
  wire  [1:0]    target  = {highPwm & ~lowPwm, lowPwm & ~highPwm};
  wire           differ  = (target != gate_r);
  wire           allOff  = (gate_r == 2'b00);

  // off first, then wait the gap before turning a side on
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      gate_r   <= 2'b00;
      cnt_r    <= '0;
      switched <= 1'b0;
    end else begin
      switched <= 1'b0;
      if (differ && !allOff) begin
        gate_r   <= 2'b00;
        cnt_r    <= deadCycles;
        switched <= 1'b1;
      end else if (differ && cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end else if (differ) begin
        gate_r   <= target;
        switched <= 1'b1;
      end else if (allOff && cnt_r != '0) begin
        // keep timing the gap while idle off
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  assign highGate = gate_r[1];
  assign lowGate  = gate_r[0];
endmodule // phase_dead_time
`default_nettype wire

// [design/oc_blanker.sv]
`timescale 1ns/1ps
`default_nettype none
module oc_blanker import gate_cfg_pkg::*; (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          rstN,
  // switching event and window
  input  wire logic          switched,
  input  wire logic [CW-1:0] blankCycles,
  // raw comparator and filtered result
  input  wire logic          ocRaw,
  output logic               ocSeen
);
  // ***************************************************************
  // blanking window
  // ***************************************************************
  logic [CW-1:0] cnt_r;  // cycles left to ignore

  // spikes right after a switch are ignored
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_r  <= '0;
      ocSeen <= 1'b0;
    end else begin
      if (switched) begin
        cnt_r <= blankCycles;
      end else if (cnt_r != '0) begin
        cnt_r <= cnt_r - 1'b1;
      end
      ocSeen <= ocRaw && (cnt_r == '0) && !switched;
    end
  end
endmodule // oc_blanker
`default_nettype wire

// [design/gate_driver_config_messages.sv]
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - cfg0 bit3 high disables undervoltage lockout
// - cfg0 bit2 high disables overcurrent detection
// - cfg0 bits1:0 pick overcurrent threshold
// - dac set answers 03H nack, 43H ack
// - dac get answers 04H/44H plus value
// - dac code is full 8-bit byte
// - cfg2 set answers 07H nack, 47H ack
// - cfg2 get answers 08H/48H plus contents
// - cfg2 bits3:2 pick dead time
// - cfg2 bits1:0 pick blanking time
// - cfg0 set answers 01H nack, 41H ack
// - cfg0 get answers 02H/42H plus contents
module gate_driver_config_messages import gate_cfg_pkg::*; #(
  parameter int PHASES = 3
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // received bytes from the link deserialiser
  input  wire logic              rxValid,
  input  wire logic [7:0]        rxByte,
  // bytes toward the link serialiser
  output logic                   txValid,
  output logic [7:0]             txByte,
  input  wire logic              txReady,
  // pwm inputs and gate outputs
  input  wire logic [PHASES-1:0] highSidePwmInput,
  input  wire logic [PHASES-1:0] lowSidePwmInput,
  output logic [PHASES-1:0]      highGate,
  output logic [PHASES-1:0]      lowGate,
  // protection
  input  wire logic              ocCompare,
  input  wire logic              supplyLow,
  output logic                   ocFault,
  output logic                   uvloFault,
  // configuration seen by the analog side
  output logic [1:0]             ocThreshold,
  output logic                   pullupDisconnect,
  output logic [7:0]             dacCode
);
  // ***************************************************************
  // reset release
  // ***************************************************************
  logic [1:0] rstSync_r;  // two-stage release
  wire        rstN = rstSync_r[1];

  // assert at once, release after two edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) rstSync_r <= 2'b00;
    else       rstSync_r <= {rstSync_r[0], 1'b1};
  end

  // ***************************************************************
  // configuration registers
  // ***************************************************************
  protection_t prot_r;   // protection config
  logic [7:0]  dac_r;    // current limit reference
  timing_t     time_r;   // driver timing config

  // ***************************************************************
  // message decode
  // ***************************************************************
  msg_state_t  state_r, state_nxt;
  logic [7:0]  code_r;       // message number of request
  logic [7:0]  ans1_r;       // first answer byte
  logic [7:0]  ans2_r;       // second answer byte

  wire         isReq    = rxValid && ((rxByte & REQ_FLAG) != 8'h00);
  wire  [7:0]  rxCode   = rxByte & CODE_MASK;
  wire         isSet    = (rxCode == MSG_SET_PROT) ||
                          (rxCode == MSG_SET_DAC) ||
                          (rxCode == MSG_SET_TIME);
  wire         isGet    = (rxCode == MSG_GET_PROT) ||
                          (rxCode == MSG_GET_DAC) ||
                          (rxCode == MSG_GET_TIME);
  // a payload with unused bits set is refused
  wire         protOk   = (rxByte & PROT_UNUSED) == 8'h00;
  wire         timeOk   = (rxByte & TIME_UNUSED) == 8'h00;
  wire         dacOk    = 1'b1;
  wire         payload  = (state_r == ST_DATA) && rxValid;
  wire         setAck   = (code_r == MSG_SET_PROT) ? protOk :
                          (code_r == MSG_SET_TIME) ? timeOk : dacOk;
  wire         wrProt   = payload && setAck && code_r == MSG_SET_PROT;
  wire         wrDac    = payload && setAck && code_r == MSG_SET_DAC;
  wire         wrTime   = payload && setAck && code_r == MSG_SET_TIME;

  // read data for a get request
  wire  [7:0]  getData  = (rxCode == MSG_GET_PROT) ? prot_r :
                          (rxCode == MSG_GET_DAC)  ? dac_r  :
                          time_r;
  // data echoed after a set: value now held
  wire  [7:0]  setData  = (code_r == MSG_SET_PROT) ?
                            (wrProt ? rxByte : prot_r) :
                          (code_r == MSG_SET_DAC) ?
                            (wrDac ? rxByte : dac_r) :
                            (wrTime ? rxByte : time_r);

  // message sequence: request, optional payload, two answer bytes
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (isReq && isSet)      state_nxt = ST_DATA;
        else if (isReq && isGet) state_nxt = ST_FIRST;
      end
      ST_DATA: begin
        if (rxValid) state_nxt = ST_FIRST;
      end
      ST_FIRST: begin
        if (txReady) state_nxt = ST_SECOND;
      end
      ST_SECOND: begin
        if (txReady) state_nxt = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // state and answer bytes
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_r <= ST_IDLE;
      code_r  <= 8'h00;
      ans1_r  <= 8'h00;
      ans2_r  <= 8'h00;
    end else begin
      state_r <= state_nxt;
      if (state_r == ST_IDLE && isReq && isGet) begin
        code_r <= rxCode;
        ans1_r <= rxCode | ACK_FLAG;
        ans2_r <= getData;
      end else if (state_r == ST_IDLE && isReq && isSet) begin
        code_r <= rxCode;
      end else if (payload) begin
        ans1_r <= setAck ? (code_r | ACK_FLAG) : code_r;
        ans2_r <= setData;
      end
    end
  end

  // byte toward the link, held until taken
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txValid <= 1'b0;
      txByte  <= 8'h00;
    end else begin
      txValid <= (state_nxt == ST_FIRST) || (state_nxt == ST_SECOND);
      txByte  <= (state_nxt == ST_SECOND) ? ans2_r :
                 (state_nxt == ST_FIRST && state_r == ST_FIRST) ? ans1_r :
                 (state_r == ST_DATA) ?
                   (setAck ? (code_r | ACK_FLAG) : code_r) :
                 (rxCode | ACK_FLAG);
    end
  end

  // ***************************************************************
  // register writes
  // ***************************************************************
  // only acked writes store
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      prot_r <= PROT_RESET;
      dac_r  <= DAC_RESET;
      time_r <= TIME_RESET;
    end else begin
      if (wrProt) prot_r <= rxByte;
      if (wrDac)  dac_r  <= rxByte;
      if (wrTime) time_r <= rxByte;
    end
  end

  // ***************************************************************
  // timing selection
  // ***************************************************************
  // dead time choice
  wire [CW-1:0] deadCycles =
    (time_r.deadSel == 2'b00) ? DEAD0_CYC :
    (time_r.deadSel == 2'b01) ? DEAD1_CYC :
    (time_r.deadSel == 2'b10) ? DEAD2_CYC : DEAD3_CYC;
  wire [CW-1:0] blankCycles =
    (time_r.blankSel == 2'b00) ? BLANK0_CYC :
    (time_r.blankSel == 2'b01) ? BLANK1_CYC :
    (time_r.blankSel == 2'b10) ? BLANK2_CYC : BLANK3_CYC;

  // ***************************************************************
  // phase drivers
  // ***************************************************************
  logic [PHASES-1:0] gateH, gateL; // gate levels per phase
  logic [PHASES-1:0] switchEv;     // gate change pulses
  logic [PHASES-1:0] ocSeen;       // blanked overcurrent

  // one gap timer and one blanker per phase
  for (genvar p = 0; p < PHASES; p++) begin : g_phase
    phase_dead_time u_dead (
      .clk        (clk),
      .rstN       (rstN),
      .highPwm    (highSidePwmInput[p]),
      .lowPwm     (lowSidePwmInput[p]),
      .deadCycles (deadCycles),
      .highGate   (gateH[p]),
      .lowGate    (gateL[p]),
      .switched   (switchEv[p])
    );
    oc_blanker u_blank (
      .clk         (clk),
      .rstN        (rstN),
      .switched    (switchEv[p]),
      .blankCycles (blankCycles),
      .ocRaw       (ocCompare),
      .ocSeen      (ocSeen[p])
    );
  end

  // ***************************************************************
  // protection outputs
  // ***************************************************************
  // lockout or overcurrent forces gates off; each fault flag follows its input every cycle, unlatched
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      highGate         <= '0;
      lowGate          <= '0;
      ocFault          <= 1'b0;
      uvloFault        <= 1'b0;
      ocThreshold      <= 2'b00;
      pullupDisconnect <= 1'b0;
      dacCode          <= DAC_RESET;
    end else begin
      uvloFault        <= supplyLow && !prot_r.uvloDisable;
      ocFault          <= (|ocSeen) && !prot_r.ocDetectDisable;
      highGate         <= (uvloFault || ocFault) ? '0 : gateH;
      lowGate          <= (uvloFault || ocFault) ? '0 : gateL;
      ocThreshold      <= prot_r.ocThreshold;
      pullupDisconnect <= prot_r.pullupDisconnect;
      dacCode          <= dac_r;
    end
  end
endmodule // gate_driver_config_messages
`default_nettype wire

// [verification/gate_cfg_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// link answer and gate timing checks
// ****************************************
module gate_cfg_assertions #(
  parameter int PHASES = 3
) (
  // clock and reset
  input wire logic              clk,
  input wire logic              nrst,
  // link bytes
  input wire logic              rxValid,
  input wire logic [7:0]        rxByte,
  input wire logic              txValid,
  input wire logic [7:0]        txByte,
  input wire logic              txReady,
  // gates and protection
  input wire logic [PHASES-1:0] highGate,
  input wire logic [PHASES-1:0] lowGate,
  input wire logic              supplyLow,
  input wire logic              ocFault,
  input wire logic              uvloFault,
  input wire logic [1:0]        ocThreshold,
  input wire logic [7:0]        dacCode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  getProt_a: assert property ((rxValid && rxByte == 8'h82 && !txValid)
    |=> txValid && (txByte == 8'h42 || txByte == 8'h02))
    else $error("bad cfg0 read answer");
  getDac_a: assert property ((rxValid && rxByte == 8'h84 && !txValid)
    |=> txValid && (txByte == 8'h44 || txByte == 8'h04))
    else $error("bad dac read answer");
  getTime_a: assert property ((rxValid && rxByte == 8'h88 && !txValid)
    |=> txValid && (txByte == 8'h48 || txByte == 8'h08))
    else $error("bad cfg2 read answer");
  setDac_a: assert property ((rxValid && rxByte == 8'h83 && !txValid)
    ##2 rxValid |=> txValid && (txByte == 8'h43 || txByte == 8'h03))
    else $error("bad dac write answer");
  setTime_a: assert property ((rxValid && rxByte == 8'h87 && !txValid)
    ##2 rxValid |=> txValid && (txByte == 8'h47 || txByte == 8'h07))
    else $error("bad cfg2 write answer");
  answerHold_a: assert property ((txValid && !txReady)
    |=> txValid && $stable(txByte))
    else $error("answer byte dropped early");
  dacFollow_a: assert property ((txValid && txReady && txByte == 8'h43)
    |=> dacCode == txByte)
    else $error("dac code not applied");
  thrFollow_a: assert property ((txValid && txReady && txByte == 8'h41)
    |=> ocThreshold == txByte[1:0])
    else $error("threshold not applied");
  uvloQuiet_a: assert property ((!supplyLow && $past(!supplyLow))
    |-> !uvloFault)
    else $error("lockout without low supply");
  faultOff_a: assert property ((ocFault || uvloFault)
    |=> highGate == '0 && lowGate == '0)
    else $error("gate on during fault");
  noShoot_a: assert property ((highGate & lowGate) == '0)
    else $error("both gates on");
  deadLow_a: assert property ($fell(lowGate[0]) |-> !highGate[0] [*7])
    else $error("dead gap too short");

  // main scenarios reached
  cover property (txValid && txReady && txByte == 8'h47);
  cover property ($fell(highGate[0]));
  cover property (ocFault);
endmodule // gate_cfg_assertions

bind gate_driver_config_messages gate_cfg_assertions #(.PHASES(PHASES)) chk (
  .clk(clk), .nrst(nrst), .rxValid(rxValid), .rxByte(rxByte),
  .txValid(txValid), .txByte(txByte), .txReady(txReady),
  .highGate(highGate), .lowGate(lowGate), .supplyLow(supplyLow),
  .ocFault(ocFault), .uvloFault(uvloFault), .ocThreshold(ocThreshold),
  .dacCode(dacCode)
);
`default_nettype wire

// [verification/host_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host side of the byte link
// ****************************************
module host_link_model (
  // clock
  input  wire logic       clk,
  // request bytes
  output logic            rxValid,
  output logic [7:0]      rxByte,
  // answer bytes
  input  wire logic       txValid,
  input  wire logic [7:0] txByte,
  output logic            txReady
);
  initial begin
    rxValid = 1'b0;
    rxByte  = 8'h5A;
    txReady = 1'b0;
  end
  task automatic send(input logic [7:0] b);
    @(posedge clk);
    #1;
    rxValid = 1'b1;
    rxByte  = b;
    @(posedge clk);
    #1;
    rxValid = 1'b0;
    rxByte  = ~b; // stale value never shown
  endtask
  // stall holds ready low to act as a slow host
  task automatic take(input int stall, output logic [7:0] b);
    int n;
    n = 0;
    while (txValid !== 1'b1 && n < 40) begin
      @(posedge clk);
      #1;
      n++;
    end
    repeat (stall) @(posedge clk);
    #1;
    txReady = 1'b1;
    @(posedge clk);
    b = txByte;
    #1;
    txReady = 1'b0;
  endtask
endmodule // host_link_model
`default_nettype wire

// [verification/gate_driver_config_messages_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// message and gate scenarios
// ****************************************
module gate_driver_config_messages_tb_top;
  logic       clk, nrst, rxValid, txValid, txReady, ocCompare, supplyLow;
  logic       ocFault, uvloFault, pullupDisconnect, slowHost;
  logic [7:0] rxByte, txByte, dacCode, v;
  logic [1:0] ocThreshold;
  logic [2:0] highPwm, lowPwm, highGate, lowGate;
  int         nMismatch, testsRun, cycles, n, d, bl;
  int         deadNs[4] = '{2000, 1000, 500, 250};
  int         blankNs[4] = '{4000, 2000, 1000, 500};
  logic [7:0] bad[3] = '{8'h80, 8'h20, 8'h10};
  logic [7:0] dacs[3] = '{8'hFF, 8'h00, 8'hA5};

  gate_driver_config_messages DUT (
    .clk(clk), .nrst(nrst), .rxValid(rxValid), .rxByte(rxByte),
    .txValid(txValid), .txByte(txByte), .txReady(txReady),
    .highSidePwmInput(highPwm), .lowSidePwmInput(lowPwm),
    .highGate(highGate), .lowGate(lowGate), .ocCompare(ocCompare),
    .supplyLow(supplyLow), .ocFault(ocFault), .uvloFault(uvloFault),
    .ocThreshold(ocThreshold), .pullupDisconnect(pullupDisconnect),
    .dacCode(dacCode));
  host_link_model HOST (
    .clk(clk), .rxValid(rxValid), .rxByte(rxByte),
    .txValid(txValid), .txByte(txByte), .txReady(txReady));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic closeOut;
    if (nMismatch == 0 && testsRun > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // hang guard, far above the thousand or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      nMismatch++;
      closeOut();
    end
  end
  task automatic check(input string what, input logic [7:0] e,
                       input logic [7:0] g);
    testsRun++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", what, e, g);
      nMismatch++;
    end
  endtask
  // one message; host alternates prompt and slow
  task automatic xfer(input logic [7:0] req, input logic [7:0] pay,
                      input bit hasPay, input logic [7:0] e1,
                      input logic [7:0] e2);
    logic [7:0] b;
    HOST.send(req);
    if (hasPay)
      HOST.send(pay);
    HOST.take(slowHost ? 3 : 0, b);
    check("first byte", e1, b);
    HOST.take(0, b);
    check("second byte", e2, b);
    slowHost = ~slowHost;
  endtask

  initial begin
    nrst = 1'b0;
    slowHost = 1'b0;
    highPwm = 3'h0;
    lowPwm = 3'h0;
    ocCompare = 1'b0;
    supplyLow = 1'b0;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (4) @(posedge clk);
    xfer(8'h82, 8'h00, 0, 8'h42, 8'h00);
    xfer(8'h84, 8'h00, 0, 8'h44, 8'h00);
    xfer(8'h88, 8'h00, 0, 8'h48, 8'h00);
    // every threshold code with both disables set, pull-up bit set on code 3
    for (int t = 0; t < 4; t++) begin
      v = 8'h0C | 8'(t) | ((t == 3) ? 8'h40 : 8'h00);
      xfer(8'h81, v, 1, 8'h41, v);
      check("threshold", {6'h00, v[1:0]}, {6'h00, ocThreshold});
      check("pullup", {7'h00, v[6]}, {7'h00, pullupDisconnect});
      xfer(8'h82, 8'h00, 0, 8'h42, v);
    end
    // unused bits refused, contents kept
    foreach (bad[i]) xfer(8'h81, bad[i], 1, 8'h01, 8'h4F);
    xfer(8'h87, 8'hF5, 1, 8'h07, 8'h00);
    foreach (dacs[i]) begin
      xfer(8'h83, dacs[i], 1, 8'h43, dacs[i]);
      check("dac code", dacs[i], dacCode);
      xfer(8'h84, 8'h00, 0, 8'h44, dacs[i]);
    end
    // lockout enabled, then disabled
    xfer(8'h81, 8'h00, 1, 8'h41, 8'h00);
    supplyLow = 1'b1;
    repeat (3) @(posedge clk);
    check("lockout", 8'h01, {7'h00, uvloFault});
    xfer(8'h81, 8'h08, 1, 8'h41, 8'h08);
    repeat (3) @(posedge clk);
    check("lockout off", 8'h00, {7'h00, uvloFault});
    #1 supplyLow = 1'b0;
    xfer(8'h81, 8'h04, 1, 8'h41, 8'h04);
    ocCompare = 1'b1;
    repeat (120) @(posedge clk);
    check("oc disabled", 8'h00, {7'h00, ocFault});
    #1 ocCompare = 1'b0;
    xfer(8'h81, 8'h00, 1, 8'h41, 8'h00);
    // each dead and blanking code on phase 0
    for (int s = 0; s < 4; s++) begin
      v = 8'(s * 5);
      d = (deadNs[s] * 25 + 999) / 1000;
      bl = (blankNs[s] * 25 + 999) / 1000;
      xfer(8'h87, v, 1, 8'h47, v);
      xfer(8'h88, 8'h00, 0, 8'h48, v);
      highPwm[0] = 1'b1;
      lowPwm[0] = 1'b0;
      repeat (80) @(posedge clk);
      #1;
      check("high gate", 8'h01, {7'h00, highGate[0]});
      highPwm[0] = 1'b0;
      lowPwm[0] = 1'b1;
      n = 0;
      while (lowGate[0] !== 1'b1 && n < 200) begin
        @(posedge clk);
        #1;
        n++;
      end
      check("dead cycles", d[7:0],
            (n >= d && n <= d + 4) ? d[7:0] : n[7:0]);
      ocCompare = 1'b1;
      repeat (2) @(posedge clk);
      check("blanked oc", 8'h00, {7'h00, ocFault});
      repeat (bl + 10) @(posedge clk);
      check("oc seen", 8'h01, {7'h00, ocFault});
      #1 ocCompare = 1'b0;
      lowPwm[0] = 1'b0;
      repeat (5) @(posedge clk);
    end
    closeOut();
  end
endmodule // gate_driver_config_messages_tb_top
`default_nettype wire
